// File: inc/fpe_pkg.sv
// Shared constants and carrier types for the flash program/erase/protect block
package fpe_pkg;

    // ==========================================================
    // Bus and array geometry
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;
    localparam logic [15:0] ARRAY_BASE_DEF  = 16'hF000;
    localparam int          ARRAY_BYTES_DEF = 4096;
    localparam int          PAGE_SHIFT      = 6;
    localparam int          ROW_SHIFT       = 5;

    // ==========================================================
    // Register and special locations
    localparam logic [15:0] CTRL_ADDR       = 16'h0040;
    localparam logic [15:0] STAT_ADDR       = 16'h0041;
    localparam logic [15:0] PROT_ADDR       = 16'hFFBE;
    localparam logic [15:0] TRIM_ADDR       = 16'hFFC0;

    // ==========================================================
    // Values
    localparam logic [7:0]  PROT_OPEN       = 8'hFF;
    localparam logic [7:0]  PROT_SAFE       = 8'h00;
    localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam logic [1:0]  PROT_TOP_BITS   = 2'h3;

    // ==========================================================
    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [3:0] rsvd;
        logic       high_voltage_enable;
        logic       mass_select;
        logic       erase_select;
        logic       program_select;
    } fpe_ctrl_t;

    // Status register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] rsvd;
        logic       armed;
        logic       hv_on;
        logic       hv_refused;
        logic       ctrl_refused;
        logic       prot_valid;
        logic       busy;
    } fpe_stat_t;

endpackage : fpe_pkg

// File: core/fpe_array_mem.sv
// Byte-wide flash array storage with one write port and a registered read port
`timescale 1ns/1ps
module fpe_array_mem #(
    parameter int AW    = 12,
    parameter int DW    = 8,
    parameter int DEPTH = 4096
) (
    input  wire logic          i_clk,
    input  wire logic          i_nrst,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [DW-1:0] i_wdata,
    input  wire logic          i_re,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [DW-1:0] o_rdata
);

    // ==========================================================
    // Storage, no reset: contents are non-volatile
    logic [DW-1:0] mem_reg [DEPTH];

    // Write port
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_reg[i_waddr] <= i_wdata;
        end
    end

    // Read port, data held until the next read
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_rdata <= '0;
        end else if (i_re) begin
            o_rdata <= mem_reg[i_raddr];
        end
    end

endmodule : fpe_array_mem

// File: core/fpe_flash_ctrl.sv
// Flash program/erase sequencer with block protection and array storage
`timescale 1ns/1ps
module fpe_flash_ctrl
    import fpe_pkg::*;
#(
    parameter logic [15:0] ARRAY_BASE  = ARRAY_BASE_DEF,
    parameter int          ARRAY_BYTES = ARRAY_BYTES_DEF
) (
    input  wire logic              i_clk,
    input  wire logic              i_nrst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    input  wire logic              i_test_voltage,
    output logic                   o_high_voltage,
    output logic                   o_busy
);

    localparam int AW = $clog2(ARRAY_BYTES);

    typedef enum logic [2:0] {SQ_IDLE, SQ_SEL, SQ_CHECKED, SQ_ARMED, SQ_HV} fpe_seq_t;

    // ==========================================================
    // Declarations
    logic            test_voltage_meta_reg;
    logic            test_voltage_reg;
    fpe_ctrl_t       ctrl_reg;
    fpe_ctrl_t       wctrl;
    fpe_stat_t       stat;
    fpe_seq_t        seq_reg;
    logic [15:0]     target_reg;
    logic [7:0]      prot_reg;
    logic            prot_valid_reg;
    logic            load_pend_reg;
    logic            load_issued_reg;
    logic            ctrl_ref_reg;
    logic            hv_ref_reg;
    logic            eng_busy_reg;
    logic            eng_mass_reg;
    logic [AW-1:0]   eng_idx_reg;
    logic [AW-1:0]   eng_last_reg;
    logic [7:0]      rdata_reg;
    logic            rd_arr_reg;
    logic            wr_ctrl;
    logic            wr_stat;
    logic            rd_prot;
    logic            arr_wr;
    logic            arr_rd;
    logic            both_req;
    logic            sel_same;
    logic            tgt_block;
    logic            mass_block;
    logic            hv_allow;
    logic            high_voltage_enable_set;
    logic            hv_ref_evt;
    logic            eng_start;
    logic            prog_we;
    logic            load_fire;
    logic            mem_we;
    logic [AW-1:0]   mem_waddr;
    logic [7:0]      mem_wdata;
    logic            mem_re;
    logic [AW-1:0]   mem_raddr;
    logic [7:0]      mem_rdata;
    logic [AW:0]     mass_cnt_reg;

    // ==========================================================
    // Address decode helpers

    // Array occupies ARRAY_BASE up to the top of the address space
    function automatic logic in_array(input logic [15:0] a);
        return a >= ARRAY_BASE;
    endfunction : in_array

    // start address from protect byte, end at FFFF
    function automatic logic prot_hit(input logic [15:0] a, input logic [7:0] p);
        return (p != PROT_OPEN) && (a >= {PROT_TOP_BITS, p, 6'h00});
    endfunction : prot_hit

    // ==========================================================
    // Test voltage pin synchroniser
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            test_voltage_meta_reg <= 1'b0;
            test_voltage_reg      <= 1'b0;
        end else begin
            test_voltage_meta_reg <= i_test_voltage;
            test_voltage_reg      <= test_voltage_meta_reg;
        end
    end

    // ==========================================================
    // Strobe decode
    assign wctrl    = fpe_ctrl_t'(i_wdata);
    assign wr_ctrl  = i_wr && (i_addr == CTRL_ADDR);
    assign wr_stat  = i_wr && (i_addr == STAT_ADDR);
    assign rd_prot  = i_rd && (i_addr == PROT_ADDR);
    assign arr_wr   = i_wr && in_array(i_addr);
    assign arr_rd   = i_rd && in_array(i_addr);
    // a write asking for both selects is refused whole
    assign both_req = wctrl.erase_select && wctrl.program_select;
    assign sel_same = (wctrl.erase_select == ctrl_reg.erase_select) &&
                      (wctrl.program_select == ctrl_reg.program_select) &&
                      (wctrl.mass_select == ctrl_reg.mass_select);

    // ==========================================================
    // High voltage gating
    // protected target blocks high voltage; test voltage lifts it
    assign tgt_block  = prot_hit(target_reg, prot_reg) && !test_voltage_reg;
    assign mass_block = ctrl_reg.erase_select && ctrl_reg.mass_select &&
                        (prot_reg != PROT_OPEN) && !test_voltage_reg;
    // only after select, protect read and target write
    assign hv_allow   = (seq_reg == SQ_ARMED) && !tgt_block && !mass_block &&
                        (ctrl_reg.erase_select || ctrl_reg.program_select);
    assign high_voltage_enable_set   = wr_ctrl && !both_req && sel_same && wctrl.high_voltage_enable &&
                        !ctrl_reg.high_voltage_enable && hv_allow;
    assign hv_ref_evt = wr_ctrl && !both_req && wctrl.high_voltage_enable &&
                        !ctrl_reg.high_voltage_enable && !high_voltage_enable_set;
    assign eng_start  = high_voltage_enable_set && ctrl_reg.erase_select;

    // ==========================================================
    // Control register; software cannot touch the protect byte here
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_reg <= fpe_ctrl_t'(CTRL_RESET);
        // interlock, refused write leaves register unchanged
        end else if (wr_ctrl && !both_req) begin
            ctrl_reg.mass_select         <= wctrl.mass_select;
            ctrl_reg.erase_select        <= wctrl.erase_select;
            ctrl_reg.program_select      <= wctrl.program_select;
            ctrl_reg.high_voltage_enable <= wctrl.high_voltage_enable &&
                                            (ctrl_reg.high_voltage_enable || high_voltage_enable_set);
            ctrl_reg.rsvd                <= '0;
        end
    end

    // ==========================================================
    // Sequence tracker: select, protect read, target write, high voltage
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            seq_reg <= SQ_IDLE;
        end else if (wr_ctrl && !both_req) begin
            if (high_voltage_enable_set) begin
                seq_reg <= SQ_HV;
            end else if (seq_reg == SQ_HV) begin
                if (!wctrl.high_voltage_enable) begin
                    seq_reg <= (wctrl.erase_select || wctrl.program_select) ? SQ_SEL : SQ_IDLE;
                end
            end else if (!(wctrl.erase_select || wctrl.program_select)) begin
                seq_reg <= SQ_IDLE;
            end else if (!sel_same || (seq_reg == SQ_IDLE)) begin
                seq_reg <= SQ_SEL;
            end
        end else if (rd_prot && (seq_reg == SQ_SEL)) begin
            seq_reg <= SQ_CHECKED;
        end else if (arr_wr && (seq_reg == SQ_CHECKED)) begin
            seq_reg <= SQ_ARMED;
        end
    end

    // first array write after the protect read is the target
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            target_reg <= '0;
        end else if (arr_wr && (seq_reg == SQ_CHECKED)) begin
            target_reg <= i_addr;
        end
    end

    // ==========================================================
    // Erase engine; far faster than real erase, software still times it
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            eng_busy_reg <= 1'b0;
            eng_mass_reg <= 1'b0;
            eng_idx_reg  <= '0;
            eng_last_reg <= '0;
        end else if (eng_start) begin
            eng_busy_reg <= 1'b1;
            eng_mass_reg <= ctrl_reg.mass_select;
            if (ctrl_reg.mass_select) begin
                eng_idx_reg  <= '0;
                eng_last_reg <= '1;
            end else begin
                eng_idx_reg  <= {target_reg[AW-1:PAGE_SHIFT], {PAGE_SHIFT{1'b0}}};
                eng_last_reg <= {target_reg[AW-1:PAGE_SHIFT], {PAGE_SHIFT{1'b1}}};
            end
        end else if (eng_busy_reg) begin
            if (eng_idx_reg == eng_last_reg) begin
                eng_busy_reg <= 1'b0;
            end else begin
                eng_idx_reg <= eng_idx_reg + 1'b1;
            end
        end
    end

    // ==========================================================
    // Array write path
    // program writes outside the target row are dropped
    // no write without an active high-voltage program phase
    assign prog_we   = arr_wr && (seq_reg == SQ_HV) && ctrl_reg.program_select &&
                       (i_addr[15:ROW_SHIFT] == target_reg[15:ROW_SHIFT]) && !eng_busy_reg;
    // vector page holds trim, so page or mass erase clears it
    assign mem_we    = eng_busy_reg || prog_we;
    assign mem_waddr = eng_busy_reg ? eng_idx_reg : i_addr[AW-1:0];
    assign mem_wdata = eng_busy_reg ? ERASED_BYTE : i_wdata;

    // Read port shared by bus reads and the post-reset protect fetch
    assign load_fire = load_pend_reg && !arr_rd;
    assign mem_re    = arr_rd || load_fire;
    assign mem_raddr = arr_rd ? i_addr[AW-1:0] : PROT_ADDR[AW-1:0];

    fpe_array_mem #(
        .AW    (AW),
        .DW    (DATA_W),
        .DEPTH (ARRAY_BYTES)
    ) u_mem (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_we    (mem_we),
        .i_waddr (mem_waddr),
        .i_wdata (mem_wdata),
        .i_re    (mem_re),
        .i_raddr (mem_raddr),
        .o_rdata (mem_rdata)
    );

    // ==========================================================
    // Protect byte shadow; fully protected until fetched after reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            load_pend_reg   <= 1'b1;
            load_issued_reg <= 1'b0;
            prot_valid_reg  <= 1'b0;
        end else begin
            if (load_fire) begin
                load_pend_reg <= 1'b0;
            end
            load_issued_reg <= load_fire;
            if (load_issued_reg) begin
                prot_valid_reg <= 1'b1;
            end
        end
    end

    // shadow follows array writes, erases and the post-reset fetch only
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // zero byte locks whole array until fetched
            prot_reg <= PROT_SAFE;
        end else if (eng_busy_reg && (eng_idx_reg == PROT_ADDR[AW-1:0])) begin
            prot_reg <= ERASED_BYTE;
        end else if (prog_we && (i_addr == PROT_ADDR)) begin
            prot_reg <= i_wdata;
        end else if (load_issued_reg) begin
            prot_reg <= mem_rdata;
        end
    end

    // ==========================================================
    // Sticky refusal flags, write one to clear, a new event wins
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_ref_reg <= 1'b0;
            hv_ref_reg   <= 1'b0;
        end else begin
            if (wr_ctrl && both_req) begin
                ctrl_ref_reg <= 1'b1;
            end else if (wr_stat && i_wdata[2]) begin
                ctrl_ref_reg <= 1'b0;
            end
            if (hv_ref_evt) begin
                hv_ref_reg <= 1'b1;
            end else if (wr_stat && i_wdata[3]) begin
                hv_ref_reg <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Read path; unmapped addresses read zero
    assign stat = '{rsvd: 2'h0, armed: (seq_reg == SQ_ARMED), hv_on: (seq_reg == SQ_HV),
                    hv_refused: hv_ref_reg, ctrl_refused: ctrl_ref_reg,
                    prot_valid: prot_valid_reg, busy: eng_busy_reg};

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_reg  <= '0;
            rd_arr_reg <= 1'b0;
        end else begin
            rd_arr_reg <= arr_rd;
            if (i_rd && (i_addr == CTRL_ADDR)) begin
                rdata_reg <= ctrl_reg;
            end else if (i_rd && (i_addr == STAT_ADDR)) begin
                rdata_reg <= stat;
            end else begin
                rdata_reg <= '0;
            end
        end
    end

    // Array data comes straight from the memory output register
    assign o_rdata        = rd_arr_reg ? mem_rdata : rdata_reg;
    assign o_high_voltage = ctrl_reg.high_voltage_enable;
    assign o_busy         = eng_busy_reg;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence s_page_start;
        eng_start && !ctrl_reg.mass_select;
    endsequence

    sequence s_page_run;
        eng_busy_reg [*8] ##56 eng_busy_reg ##1 !eng_busy_reg;
    endsequence

    property p_interlock;
        !(ctrl_reg.erase_select && ctrl_reg.program_select);
    endproperty
    a_interlock: assert property (p_interlock) else $error("both selects set");

    property p_refuse_both;
        wr_ctrl && both_req |=> $stable(ctrl_reg) && ctrl_ref_reg;
    endproperty
    a_refuse_both: assert property (p_refuse_both) else $error("double select write not refused");

    property p_page_len;
        s_page_start |=> s_page_run;
    endproperty
    a_page_len: assert property (p_page_len) else $error("page erase not 64 cycles");

    property p_mass_block;
        $rose(ctrl_reg.high_voltage_enable) |->
            !($past(ctrl_reg.mass_select) && ($past(prot_reg) != PROT_OPEN) && !$past(test_voltage_reg));
    endproperty
    a_mass_block: assert property (p_mass_block) else $error("mass erase with protection");

    property p_row_confine;
        mem_we && !eng_busy_reg |-> (i_addr[15:ROW_SHIFT] == target_reg[15:ROW_SHIFT]);
    endproperty
    a_row_confine: assert property (p_row_confine) else $error("program outside row");

    property p_target_latch;
        arr_wr && (seq_reg == SQ_CHECKED) |=> (seq_reg == SQ_ARMED) && (target_reg == $past(i_addr));
    endproperty
    a_target_latch: assert property (p_target_latch) else $error("target not latched");

    property p_hv_prot;
        $rose(ctrl_reg.high_voltage_enable) |-> !$past(tgt_block) && ($past(seq_reg) == SQ_ARMED);
    endproperty
    a_hv_prot: assert property (p_hv_prot) else $error("high voltage on protected target");

    // Mass erase runs too long for a delay range, so its cycles are counted here
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            mass_cnt_reg <= '0;
        end else if (eng_start) begin
            mass_cnt_reg <= '0;
        end else if (eng_busy_reg && eng_mass_reg) begin
            mass_cnt_reg <= mass_cnt_reg + 1'b1;
        end
    end

    property p_mass_ones;
        $fell(eng_busy_reg) && eng_mass_reg |->
            (mass_cnt_reg == (AW+1)'(ARRAY_BYTES)) && (prot_reg == PROT_OPEN);
    endproperty
    a_mass_ones: assert property (p_mass_ones) else $error("mass erase left protect byte");

    property p_idle_write;
        arr_wr && !(ctrl_reg.erase_select || ctrl_reg.program_select) |-> !prog_we;
    endproperty
    a_idle_write: assert property (p_idle_write) else $error("unselected write changed array");

endmodule : fpe_flash_ctrl

// File: test/fpe_flash_ctrl_bench.sv
// Self-checking bench for the flash program/erase/protect sequencer
`timescale 1ns/1ps
module fpe_flash_ctrl_bench
    import fpe_pkg::*;
;
    // ==========================================================
    // Stimulus and observation signals
    logic        clk     = 1'b0;
    logic        nrst    = 1'b0;
    logic        wr_s    = 1'b0;
    logic        rd_s    = 1'b0;
    logic        tv      = 1'b0;
    logic [15:0] addr    = 16'h0000;
    logic [7:0]  wdata   = 8'h00;
    logic [7:0]  rdata;
    logic        hv_out;
    logic        busy;
    logic [7:0]  rdv;
    logic        hv;
    int          n;
    int          fail_count  = 0;
    int          checks_done = 0;
    // Control rows: value written, value read back
    logic [7:0]  wv [7] = '{8'h04, 8'h06, 8'h02, 8'h01, 8'h03, 8'hF4, 8'h00};
    logic [7:0]  ev [7] = '{8'h04, 8'h06, 8'h02, 8'h01, 8'h01, 8'h04, 8'h00};

    // 200 MHz clock
    always #2.5 clk = ~clk;

    fpe_flash_ctrl dut (
        .i_clk          (clk),
        .i_nrst         (nrst),
        .i_addr         (addr),
        .i_wdata        (wdata),
        .i_wr           (wr_s),
        .i_rd           (rd_s),
        .o_rdata        (rdata),
        .i_test_voltage (tv),
        .o_high_voltage (hv_out),
        .o_busy         (busy)
    );

    // ==========================================================
    // Shared tasks
    task report_and_stop;
        if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    task chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask : wr

    // Data stands only in the cycle after the strobe
    task rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask : rd

    task rchk(input logic [15:0] a, input logic [7:0] e);
        rd(a, rdv);
        chk({8'h00, rdv}, {8'h00, e});
    endtask : rchk

    // High voltage shows just after the edge that takes the control write
    task hv_step(input logic [7:0] c);
        wr(CTRL_ADDR, c);
        #1 hv = hv_out;
    endtask : hv_step

    task prog(input logic [15:0] row, input logic [15:0] a, input logic [7:0] d);
        wr(CTRL_ADDR, 8'h01);
        rd(PROT_ADDR, rdv);
        wr(row, 8'hFF);
        hv_step(8'h09);
        wr(a, d);
        wr(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h00);
    endtask : prog

    // erase step order
    // Counts busy cycles; a refused start leaves the count at zero
    task erase(input logic mass, input logic [15:0] a);
        wr(CTRL_ADDR, mass ? 8'h06 : 8'h02);
        rd(PROT_ADDR, rdv);
        wr(a, 8'h00);
        hv_step(mass ? 8'h0E : 8'h0A);
        n = 0;
        while (busy === 1'b1 && n < 5000) begin
            n++;
            @(posedge clk);
            #1;
        end
        if (n >= 5000) begin
            fail_count++;
            $display("Error at %0t: erase never finished", $time);
            report_and_stop;
        end
        wr(CTRL_ADDR, 8'h08);
        wr(CTRL_ADDR, 8'h00);
    endtask : erase

    task rst;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : rst

    task tvset(input logic v);
        tv <= v;
        repeat (5) @(posedge clk);
    endtask : tvset

    // ==========================================================
    // Main sequence
    initial begin
        rst;
        chk({14'h0, hv_out, busy}, 16'h0000);
        rchk(CTRL_ADDR, CTRL_RESET);
        rchk(STAT_ADDR, 8'h02);
        rchk(16'h0042, 8'h00);
        // Array starts unknown: test voltage allows the first mass erase
        tvset(1'b1);
        erase(1'b1, 16'hF000);
        chk({15'h0, hv}, 16'h0001);
        chk(n[15:0], 16'd4096);
        rchk(16'hF000, ERASED_BYTE);
        rchk(TRIM_ADDR, ERASED_BYTE);
        rchk(PROT_ADDR, PROT_OPEN);
        tvset(1'b0);
        rst;
        rchk(STAT_ADDR, 8'h02);
        // Control readback table
        for (int i = 0; i < 7; i++) begin
            wr(CTRL_ADDR, wv[i]);
            rchk(CTRL_ADDR, ev[i]);
        end
        rd(STAT_ADDR, rdv);
        chk({15'h0, rdv[2]}, 16'h0001);
        // High voltage without the protect read and target write
        wr(CTRL_ADDR, 8'h02);
        hv_step(8'h0A);
        chk({15'h0, hv}, 16'h0000);
        wr(CTRL_ADDR, 8'h00);
        // each byte programmed once
        // Programming confined to the latched row
        prog(16'hF100, 16'hF100, 8'hA5);
        chk({15'h0, hv}, 16'h0001);
        prog(16'hF100, 16'hF11F, 8'h3C);
        prog(16'hF100, 16'hF120, 8'h77);
        prog(16'hF140, 16'hF140, 8'h5A);
        rchk(16'hF100, 8'hA5);
        rchk(16'hF11F, 8'h3C);
        rchk(16'hF120, ERASED_BYTE);
        wr(16'hF141, 8'h12);
        rchk(16'hF141, ERASED_BYTE);
        // Page erase clears one 64-byte page only
        erase(1'b0, 16'hF110);
        chk(n[15:0], 16'd64);
        rchk(16'hF100, ERASED_BYTE);
        rchk(16'hF11F, ERASED_BYTE);
        rchk(16'hF140, 8'h5A);
        // Protect from FF80 upward, shadow refetched by reset
        prog(16'hFFA0, PROT_ADDR, 8'hFE);
        rst;
        prog(16'hFF80, 16'hFF80, 8'h11);
        chk({15'h0, hv}, 16'h0000);
        rchk(16'hFF80, ERASED_BYTE);
        prog(16'hFF40, 16'hFF40, 8'h22);
        rchk(16'hFF40, 8'h22);
        erase(1'b1, 16'hF000);
        chk({15'h0, hv}, 16'h0000);
        chk(n[15:0], 16'd0);
        wr(PROT_ADDR, 8'h00);
        rchk(PROT_ADDR, 8'hFE);
        prog(16'hFFA0, PROT_ADDR, 8'h00);
        chk({15'h0, hv}, 16'h0000);
        rchk(PROT_ADDR, 8'hFE);
        // Test voltage lifts the lock for a mass erase
        tvset(1'b1);
        erase(1'b1, PROT_ADDR);
        chk({15'h0, hv}, 16'h0001);
        chk(n[15:0], 16'd4096);
        rchk(PROT_ADDR, PROT_OPEN);
        rchk(16'hFF40, ERASED_BYTE);
        report_and_stop;
    end
endmodule : fpe_flash_ctrl_bench
